// [hw/htscr_regs.sv]
// Purpose: register bank and measurement sequencing of the humidity sensor
// Assumes: serial framing decoded outside into one-cycle read/write strobes
// Notes: nonvolatile memory answers its address within the same cycle
//        host writes to calibration bytes are taken; a reload restores them
`timescale 1ns/10ps
module htscr_regs
   import htscr_pkg::*;
#(
   parameter int P_CNT_1HZ = CNT_1HZ,
   parameter int P_CNT_7HZ = CNT_7HZ,
   parameter int P_CNT_12HZ5 = CNT_12HZ5
)
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic i_wr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   output logic [3:0] o_nvm_addr,
   input wire logic [DATA_W-1:0] i_nvm_data,
   output logic o_conv_start,
   input wire logic i_conv_done,
   input wire logic [15:0] i_hum_sample,
   input wire logic [15:0] i_temp_sample,
   output logic o_active,
   output logic o_heater_en,
   output logic [8:0] o_temp_avg_count,
   output logic [9:0] o_hum_avg_count,
   output logic o_boot_busy
);
   // register state
   logic [7:0] avg_r, avg_nxt;
   logic [7:0] ctrl1_r, ctrl1_nxt;
   logic [7:0] ctrl3_r, ctrl3_nxt;
   logic reload_r, reload_nxt;
   logic heater_r, heater_nxt;
   logic oneshot_r, oneshot_nxt;
   logic hum_rdy_r, hum_rdy_nxt;
   logic temp_rdy_r, temp_rdy_nxt;
   // no reset here: the copy after reset fills every byte
   logic [7:0] calib_mem [0:CALIB_N-1];
   logic [7:0] rdata_r, rdata_nxt;
   logic [8:0] tavg_cnt_r;
   logic [9:0] havg_cnt_r;

   // sequencer state
   htscr_state_type state_r, state_nxt;
   logic [3:0] nvm_addr_r, nvm_addr_nxt;
   logic conv_start_r, conv_start_nxt;
   logic conv_oneshot_r, conv_oneshot_nxt;
   logic [RATE_CNT_W-1:0] rate_cnt_r, rate_cnt_nxt;
   logic periodic_pend_r, periodic_pend_nxt;
   logic busy_r, busy_nxt;

   // address decode
   logic sel_id, sel_avg, sel_ctrl1, sel_ctrl2, sel_ctrl3;
   logic sel_status, sel_hum_l, sel_hum_h, sel_temp_l, sel_temp_h;
   logic sel_calib;
   logic wr_avg, wr_ctrl1, wr_ctrl2, wr_ctrl3, wr_calib;
   logic rd_hum_l, rd_hum_h, rd_temp_l, rd_temp_h;

   // plain address compare, seven bits wide
   assign sel_id = (i_addr == A_DEVICE_ID);
   assign sel_avg = (i_addr == A_AVG_CFG);
   assign sel_ctrl1 = (i_addr == A_CTRL1);
   assign sel_ctrl2 = (i_addr == A_CTRL2);
   assign sel_ctrl3 = (i_addr == A_CTRL3);
   assign sel_status = (i_addr == A_STATUS);
   assign sel_hum_l = (i_addr == A_HUM_L);
   assign sel_hum_h = (i_addr == A_HUM_H);
   assign sel_temp_l = (i_addr == A_TEMP_L);
   assign sel_temp_h = (i_addr == A_TEMP_H);
   // sixteen calibration bytes share the upper address bits
   // low four address bits index them for reads and writes
   assign sel_calib = (i_addr[6:4] == A_CALIB[6:4]);

   // write strobes; reserved and read-only addresses have none
   assign wr_avg = i_wr & sel_avg;
   assign wr_ctrl1 = i_wr & sel_ctrl1;
   assign wr_ctrl2 = i_wr & sel_ctrl2;
   assign wr_ctrl3 = i_wr & sel_ctrl3;
   assign wr_calib = i_wr & sel_calib;

   // read strobes with side effects
   assign rd_hum_l = i_rd & sel_hum_l;
   assign rd_hum_h = i_rd & sel_hum_h;
   assign rd_temp_l = i_rd & sel_temp_l;
   assign rd_temp_h = i_rd & sel_temp_h;

   // decoded control fields
   logic active, hold_en;
   logic [1:0] rate_sel;
   logic [2:0] temp_avg_select, hum_avg_select;
   assign active = ctrl1_r[B_ACTIVE];
   assign hold_en = ctrl1_r[B_HOLD];
   assign rate_sel = ctrl1_r[B_RATE_HI:B_RATE_LO];
   assign temp_avg_select = avg_r[B_TAVG_HI:B_TAVG_LO];
   assign hum_avg_select = avg_r[B_HAVG_HI:B_HAVG_LO];

   // state decodes shared by the copy, start and flag logic
   logic in_boot, in_idle, in_conv;
   assign in_boot = (state_r == ST_BOOT);
   assign in_idle = (state_r == ST_IDLE);
   assign in_conv = (state_r == ST_CONV);

   // result pairs, with pair hold; both load on the same done pulse
   logic [15:0] hum_value, temp_value;
   logic conv_done_ok;
   // a stray done pulse outside a conversion cannot set flags
   assign conv_done_ok = i_conv_done & in_conv;

   htscr_out_pair u_hum_pair (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_load(conv_done_ok),
      .i_sample(i_hum_sample),
      .i_hold_en(hold_en),
      .i_rd_low(rd_hum_l),
      .i_rd_high(rd_hum_h),
      .o_value(hum_value)
   );

   htscr_out_pair u_temp_pair (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_load(conv_done_ok),
      .i_sample(i_temp_sample),
      .i_hold_en(hold_en),
      .i_rd_low(rd_temp_l),
      .i_rd_high(rd_temp_h),
      .o_value(temp_value)
   );

   // configuration writes, reserved bits masked to zero
   assign avg_nxt = wr_avg ? (i_wdata & M_AVG_CFG) : avg_r;
   assign ctrl1_nxt = wr_ctrl1 ? (i_wdata & M_CTRL1) : ctrl1_r;
   assign ctrl3_nxt = wr_ctrl3 ? (i_wdata & M_CTRL3) : ctrl3_r;
   // heater follows only the host's write
   assign heater_nxt = wr_ctrl2 ? i_wdata[B_HEATER] : heater_r;

   // reload bit: a write of one wins over the completion clear
   // a reload asked for mid-conversion waits for the engine to finish
   logic boot_done;
   assign boot_done = in_boot & (nvm_addr_r == 4'hF);
   assign reload_nxt = (wr_ctrl2 & i_wdata[B_RELOAD]) |
                       (reload_r & ~boot_done);

   // one-shot bit: host write of one wins over the hardware clear
   // writing zero cancels a one-shot that has not started
   logic oneshot_clr;
   assign oneshot_clr = conv_done_ok & conv_oneshot_r;
   assign oneshot_nxt = wr_ctrl2 ? i_wdata[B_ONESHOT] :
                        (oneshot_r & ~oneshot_clr);

   // ready flags: a new sample wins over the clearing read
   assign hum_rdy_nxt = conv_done_ok | (hum_rdy_r & ~rd_hum_h);
   assign temp_rdy_nxt = conv_done_ok | (temp_rdy_r & ~rd_temp_h);

   // rate period in cycles for the selected code
   // counter runs only in periodic mode, so each run starts a full period
   logic [RATE_CNT_W-1:0] rate_limit;
   logic rate_run, rate_tick;
   assign rate_limit = (rate_sel == RATE_1HZ) ? RATE_CNT_W'(P_CNT_1HZ - 1) :
                       (rate_sel == RATE_7HZ) ? RATE_CNT_W'(P_CNT_7HZ - 1) :
                       RATE_CNT_W'(P_CNT_12HZ5 - 1);
   assign rate_run = active & (rate_sel != RATE_ONESHOT);
   // compare with >= so a shorter period after a rate change still ends
   assign rate_tick = rate_run & (rate_cnt_r >= rate_limit);
   assign rate_cnt_nxt = (!rate_run || rate_tick) ? '0 :
                         rate_cnt_r + RATE_CNT_W'(1);
   // one pending periodic start; extra ticks during a conversion merge
   logic start_any, start_oneshot;
   // a pending reload goes first so no conversion runs on half-copied trims
   assign start_oneshot = in_idle & ~reload_r & active &
                          oneshot_r;
   assign start_any = in_idle & ~reload_r & active &
                      (oneshot_r | periodic_pend_r);
   assign periodic_pend_nxt = rate_tick | (periodic_pend_r & ~start_any & rate_run);

   // busy has its own flop so the port carries no state decode
   assign busy_nxt = (state_nxt == ST_BOOT);

   // sequencer next state: reload first, then conversions
   always_comb begin
      state_nxt = state_r;
      nvm_addr_nxt = nvm_addr_r;
      conv_start_nxt = 1'b0;
      conv_oneshot_nxt = conv_oneshot_r;
      unique case (state_r)
         ST_BOOT: begin
            nvm_addr_nxt = nvm_addr_r + 4'h1;
            if (boot_done) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (reload_r) begin
               state_nxt = ST_BOOT;
               nvm_addr_nxt = 4'h0;
            end else if (start_any) begin
               state_nxt = ST_CONV;
               conv_start_nxt = 1'b1;
               conv_oneshot_nxt = start_oneshot;
            end
         end
         ST_CONV: begin
            if (i_conv_done) begin
               state_nxt = ST_IDLE;
               conv_oneshot_nxt = 1'b0;
            end
         end
         // the unused code restarts the copy rather than hang
         default: begin
            state_nxt = ST_BOOT;
            nvm_addr_nxt = 4'h0;
         end
      endcase
   end

   // calibration bytes: copied while booting, host writes otherwise
   always_ff @(posedge i_clock) begin
      if (in_boot) begin
         calib_mem[nvm_addr_r] <= i_nvm_data;
      end else if (wr_calib) begin
         calib_mem[i_addr[3:0]] <= i_wdata;
      end
   end

   // read mux; reserved addresses read zero
   always_comb begin
      rdata_nxt = 8'h00;
      if (sel_id) begin
         rdata_nxt = DEVICE_ID_CODE;
      end else if (sel_avg) begin
         rdata_nxt = avg_r;
      end else if (sel_ctrl1) begin
         rdata_nxt = ctrl1_r;
      end else if (sel_ctrl2) begin
         rdata_nxt = {reload_r, 5'h00, heater_r, oneshot_r};
      end else if (sel_ctrl3) begin
         rdata_nxt = ctrl3_r;
      end else if (sel_status) begin
         rdata_nxt = {6'h00, hum_rdy_r, temp_rdy_r};
      end else if (sel_hum_l) begin
         rdata_nxt = hum_value[7:0];
      end else if (sel_hum_h) begin
         rdata_nxt = hum_value[15:8];
      end else if (sel_temp_l) begin
         rdata_nxt = temp_value[7:0];
      end else if (sel_temp_h) begin
         rdata_nxt = temp_value[15:8];
      end else if (sel_calib) begin
         rdata_nxt = calib_mem[i_addr[3:0]];
      end
   end

   // host-written configuration
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         avg_r <= R_AVG_CFG;
         ctrl1_r <= R_CTRL;
         ctrl3_r <= R_CTRL;
         heater_r <= 1'b0;
      end else begin
         avg_r <= avg_nxt;
         ctrl1_r <= ctrl1_nxt;
         ctrl3_r <= ctrl3_nxt;
         heater_r <= heater_nxt;
      end
   end

   // self-clearing command bits and ready flags
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         reload_r <= 1'b0;
         oneshot_r <= 1'b0;
         hum_rdy_r <= 1'b0;
         temp_rdy_r <= 1'b0;
      end else begin
         reload_r <= reload_nxt;
         oneshot_r <= oneshot_nxt;
         hum_rdy_r <= hum_rdy_nxt;
         temp_rdy_r <= temp_rdy_nxt;
      end
   end

   // sequencer registers; reset lands in boot so trims load first
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state_r <= ST_BOOT;
         nvm_addr_r <= 4'h0;
         busy_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         nvm_addr_r <= nvm_addr_nxt;
         busy_r <= busy_nxt;
      end
   end

   // conversion start and rate timing
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         conv_start_r <= 1'b0;
         conv_oneshot_r <= 1'b0;
         rate_cnt_r <= '0;
         periodic_pend_r <= 1'b0;
      end else begin
         conv_start_r <= conv_start_nxt;
         conv_oneshot_r <= conv_oneshot_nxt;
         rate_cnt_r <= rate_cnt_nxt;
         periodic_pend_r <= periodic_pend_nxt;
      end
   end

   // registered read data, held between reads
   // held so a slow serial shifter can take the byte at its own pace
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         rdata_r <= 8'h00;
      end else if (i_rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   // averaging depths as sample counts for the engine
   // registered so the engine never sees a code mid-write
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         tavg_cnt_r <= 9'h010;
         havg_cnt_r <= 10'h020;
      end else begin
         tavg_cnt_r <= 9'h002 << temp_avg_select;
         havg_cnt_r <= 10'h004 << hum_avg_select;
      end
   end

   // outputs straight from flops
   assign o_rdata = rdata_r;
   assign o_nvm_addr = nvm_addr_r;
   assign o_conv_start = conv_start_r;
   assign o_active = ctrl1_r[B_ACTIVE];
   assign o_heater_en = heater_r;
   assign o_temp_avg_count = tavg_cnt_r;
   assign o_hum_avg_count = havg_cnt_r;
   assign o_boot_busy = busy_r;
endmodule

// [hw/htscr_pkg.sv]
// Purpose: constants, register map and types of the sensor control registers
// Assumes: 25 MHz core clock, 8-bit registers behind a 7-bit register address
// Notes:
// Notes on behaviour
// - every visible register is one byte at its own address in one flat map
// - calibration bytes load from nonvolatile memory at power-on; host leaves them (host writes are taken here)
// - registers are selected by a seven-bit register address
// - identification register is read-only and always returns a fixed code
// - temperature averaging code picks 2 to 256 samples, doubling per step
// - humidity averaging code picks 4 to 512 samples; both codes reset to 011
// - active bit low means power-down, its reset value; high means active
// - hold bit set freezes an output pair after one half read until other half
// - rate code selects one-shot, 1 Hz, 7 Hz or 12.5 Hz conversions
// - at power-up nonvolatile contents are copied into trimming registers
// - writing the reload bit recopies trims; hardware clears it when done
// - writing the one-shot bit starts one combined acquisition; reads 0 when idle
// - one-shot end loads results, sets both ready flags, clears one-shot bit
// - heater bit switches the heater; only host writes change it
// - ready flags set on new samples and clear on reading their high byte
// - status updates after every conversion regardless of the hold bit
// - each result is sixteen-bit two's complement split in low and high byte
package htscr_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int CALIB_N = 16;
   localparam int RATE_CNT_W = 25;
   // register addresses
   localparam logic [6:0] A_DEVICE_ID = 7'h0F;
   localparam logic [6:0] A_AVG_CFG = 7'h10;
   localparam logic [6:0] A_CTRL1 = 7'h20;
   localparam logic [6:0] A_CTRL2 = 7'h21;
   localparam logic [6:0] A_CTRL3 = 7'h22;
   localparam logic [6:0] A_STATUS = 7'h27;
   localparam logic [6:0] A_HUM_L = 7'h28;
   localparam logic [6:0] A_HUM_H = 7'h29;
   localparam logic [6:0] A_TEMP_L = 7'h2A;
   localparam logic [6:0] A_TEMP_H = 7'h2B;
   localparam logic [6:0] A_CALIB = 7'h30;
   // identification code; value is arbitrary
   localparam logic [7:0] DEVICE_ID_CODE = 8'h5A;
   // writable bit masks, reserved bits stay zero
   localparam logic [7:0] M_AVG_CFG = 8'h3F;
   localparam logic [7:0] M_CTRL1 = 8'h87;
   localparam logic [7:0] M_CTRL3 = 8'hC4;
   // reset values
   localparam logic [7:0] R_AVG_CFG = 8'h1B;
   localparam logic [7:0] R_CTRL = 8'h00;
   // field positions
   localparam int B_ACTIVE = 7;
   localparam int B_HOLD = 2;
   localparam int B_RATE_HI = 1;
   localparam int B_RATE_LO = 0;
   localparam int B_RELOAD = 7;
   localparam int B_HEATER = 1;
   localparam int B_ONESHOT = 0;
   localparam int B_HUM_RDY = 1;
   localparam int B_TEMP_RDY = 0;
   localparam int B_TAVG_HI = 5;
   localparam int B_TAVG_LO = 3;
   localparam int B_HAVG_HI = 2;
   localparam int B_HAVG_LO = 0;
   // rate codes
   localparam logic [1:0] RATE_ONESHOT = 2'h0;
   localparam logic [1:0] RATE_1HZ = 2'h1;
   localparam logic [1:0] RATE_7HZ = 2'h2;
   localparam logic [1:0] RATE_12HZ5 = 2'h3;
   // timing: periods in ns, counts in clock cycles
   localparam int CLK_PERIOD_NS = 40;
   localparam int PER_1HZ_NS = 1000000000;
   localparam int PER_7HZ_NS = 142857142;
   localparam int PER_12HZ5_NS = 80000000;
   localparam int CNT_1HZ = PER_1HZ_NS / CLK_PERIOD_NS;
   localparam int CNT_7HZ = PER_7HZ_NS / CLK_PERIOD_NS;
   localparam int CNT_12HZ5 = PER_12HZ5_NS / CLK_PERIOD_NS;
   // sequencer states, gray along boot, idle, convert
   typedef enum logic [1:0] {
      ST_BOOT = 2'h0,
      ST_IDLE = 2'h1,
      ST_CONV = 2'h3
   } htscr_state_type;
endpackage

// [hw/htscr_out_pair.sv]
// Purpose: one sixteen-bit result shown as two bytes, with optional pair hold
// Assumes: read strobes are one-cycle pulses from the register port
// Notes: latest sample waits in a shadow while the shown value is frozen
`timescale 1ns/10ps
module htscr_out_pair
   import htscr_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_load,
   input wire logic [15:0] i_sample,
   input wire logic i_hold_en,
   input wire logic i_rd_low,
   input wire logic i_rd_high,
   output logic [15:0] o_value
);
   logic lo_seen_r, lo_seen_nxt;
   logic hi_seen_r, hi_seen_nxt;
   logic [15:0] shadow_r, shadow_nxt;
   logic [15:0] shown_r, shown_nxt;
   logic frozen_nxt;

   // pair tracking: second half read closes the pair
   assign lo_seen_nxt = i_hold_en & ((i_rd_low & ~hi_seen_r & ~i_rd_high) |
                        (lo_seen_r & ~i_rd_high));
   assign hi_seen_nxt = i_hold_en & ((i_rd_high & ~lo_seen_r & ~i_rd_low) |
                        (hi_seen_r & ~i_rd_low));
   assign frozen_nxt = lo_seen_nxt | hi_seen_nxt;
   assign shadow_nxt = i_load ? i_sample : shadow_r;
   // frozen pair keeps both halves from one sample
   assign shown_nxt = frozen_nxt ? shown_r : shadow_nxt;
   assign o_value = shown_r;

   // state registers
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         lo_seen_r <= 1'b0;
         hi_seen_r <= 1'b0;
         shadow_r <= 16'h0000;
         shown_r <= 16'h0000;
      end else begin
         lo_seen_r <= lo_seen_nxt;
         hi_seen_r <= hi_seen_nxt;
         shadow_r <= shadow_nxt;
         shown_r <= shown_nxt;
      end
   end
endmodule

// [verification/htscr_regs_assertions.sv]
// Purpose: port checks of the sensor register bank
// Assumes: one clock, synchronous active-low reset
// Notes: averaging counts may trail their write by up to two cycles
`timescale 1ns/10ps
module htscr_regs_assertions
   import htscr_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic i_wr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic [3:0] o_nvm_addr,
   input wire logic o_conv_start,
   input wire logic o_active,
   input wire logic o_heater_en,
   input wire logic [8:0] o_temp_avg_count,
   input wire logic [9:0] o_hum_avg_count,
   input wire logic o_boot_busy
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   // strobe decodes; gaps are the unmapped addresses below the calibration block
   wire logic wr_avg = i_wr && (i_addr == A_AVG_CFG);
   wire logic wr_one = i_wr && (i_addr == A_CTRL1);
   wire logic wr_two = i_wr && (i_addr == A_CTRL2);
   wire logic rd_id = i_rd && (i_addr == A_DEVICE_ID);
   wire logic rd_gap = i_rd && (i_addr inside {[7'h00:7'h0E], [7'h11:7'h1F],
      [7'h23:7'h26], [7'h2C:7'h2F]});
   // properties
   property p_start; o_conv_start |=> !o_conv_start; endproperty
   a_start: assert property (p_start) else $error("start pulse too long");
   property p_boot_end; o_boot_busy && o_nvm_addr == 4'hF |=> !o_boot_busy; endproperty
   a_boot_end: assert property (p_boot_end) else $error("copy overran");
   property p_boot_step;
      o_boot_busy && o_nvm_addr != 4'hF |=> o_boot_busy && o_nvm_addr == $past(o_nvm_addr) + 4'h1;
   endproperty
   a_boot_step: assert property (p_boot_step) else $error("copy step wrong");
   property p_active; wr_one |=> o_active == $past(i_wdata[B_ACTIVE]); endproperty
   a_active: assert property (p_active) else $error("active bit not taken");
   property p_heat; wr_two |=> o_heater_en == $past(i_wdata[B_HEATER]); endproperty
   a_heat: assert property (p_heat) else $error("heater not taken");
   property p_heat_keep; !wr_two |=> $stable(o_heater_en); endproperty
   a_heat_keep: assert property (p_heat_keep) else $error("heater moved alone");
   property p_tavg;
      wr_avg |-> ##2 o_temp_avg_count == (9'h002 << $past(i_wdata[5:3], 2));
   endproperty
   a_tavg: assert property (p_tavg) else $error("temp average count");
   property p_havg;
      wr_avg |-> ##2 o_hum_avg_count == (10'h004 << $past(i_wdata[2:0], 2));
   endproperty
   a_havg: assert property (p_havg) else $error("hum average count");
   property p_id; rd_id |=> o_rdata == DEVICE_ID_CODE; endproperty
   a_id: assert property (p_id) else $error("id code wrong");
   property p_gap; rd_gap |=> o_rdata == 8'h00; endproperty
   a_gap: assert property (p_gap) else $error("gap read not zero");
   // main scenarios reached
   c_start: cover property (o_conv_start);
   c_boot: cover property ($fell(o_boot_busy));
   c_id: cover property (rd_id);
endmodule
bind htscr_regs htscr_regs_assertions u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
   .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_nvm_addr(o_nvm_addr), .o_conv_start(o_conv_start), .o_active(o_active),
   .o_heater_en(o_heater_en), .o_temp_avg_count(o_temp_avg_count),
   .o_hum_avg_count(o_hum_avg_count), .o_boot_busy(o_boot_busy));

// [verification/htscr_sense_model.sv]
// Purpose: trim memory and measurement engine beside the register bank
// Assumes: memory answers its address in the same cycle
// Notes: samples are only valid with the done pulse
`timescale 1ns/10ps
module htscr_sense_model
   import htscr_pkg::*;
(
   input wire logic i_clock,
   input wire logic [3:0] i_nvm_addr,
   input wire logic [7:0] i_trim_xor,
   input wire logic i_slow,
   input wire logic i_conv_start,
   output logic [7:0] o_nvm_data,
   output logic o_conv_done,
   output logic [15:0] o_hum,
   output logic [15:0] o_temp
);
   logic [15:0] hum_v = 16'hC0F1;
   logic [15:0] temp_v = 16'h1E2D;
   int wait_n = 0;
   // trim bytes, changed by the xor input so a recopy is visible
   assign o_nvm_data = 8'h3C ^ {i_nvm_addr, i_nvm_addr} ^ i_trim_xor;
   // outside done the lines show inverted data, not stale values
   assign o_hum = o_conv_done ? hum_v : ~hum_v;
   assign o_temp = o_conv_done ? temp_v : ~temp_v;
   // one conversion at a time, short or long
   always @(posedge i_clock) begin
      o_conv_done <= 1'b0;
      if (i_conv_start) begin
         wait_n <= i_slow ? 24 : 3;
      end else if (wait_n != 0) begin
         wait_n <= wait_n - 1;
      end
      if (!i_conv_start && wait_n == 1) begin
         o_conv_done <= 1'b1;
         hum_v <= hum_v + 16'h0111;
         temp_v <= temp_v - 16'h0203;
      end
   end
endmodule

// [verification/htscr_regs_bench.sv]
// Purpose: self-checking bench of the sensor register bank
// Assumes: host strobes change on the falling edge
// Notes: rate counts shortened to 40/30/20 cycles
`timescale 1ns/10ps
module htscr_regs_bench
   import htscr_pkg::*;
;
   localparam int PER [3] = '{40, 30, 20};
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic [6:0] i_addr = 7'h00;
   logic i_wr = 1'b0;
   logic [7:0] i_wdata = 8'h00;
   logic i_rd = 1'b0;
   logic [7:0] trim_xor = 8'h00;
   logic slow = 1'b1;
   logic [7:0] o_rdata, nvm_data;
   logic [3:0] o_nvm_addr;
   logic o_conv_start, conv_done, o_active, o_heater_en, o_boot_busy;
   logic [15:0] hum, temp, h1, t1;
   logic [8:0] o_temp_avg_count;
   logic [9:0] o_hum_avg_count;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int k, t0;
   htscr_regs #(.P_CNT_1HZ(PER[0]), .P_CNT_7HZ(PER[1]), .P_CNT_12HZ5(PER[2])) uut (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr),
      .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata), .o_nvm_addr(o_nvm_addr),
      .i_nvm_data(nvm_data), .o_conv_start(o_conv_start), .i_conv_done(conv_done),
      .i_hum_sample(hum), .i_temp_sample(temp), .o_active(o_active),
      .o_heater_en(o_heater_en), .o_temp_avg_count(o_temp_avg_count),
      .o_hum_avg_count(o_hum_avg_count), .o_boot_busy(o_boot_busy));
   htscr_sense_model mdl (.i_clock(i_clock), .i_nvm_addr(o_nvm_addr), .i_trim_xor(trim_xor),
      .i_slow(slow), .i_conv_start(o_conv_start), .o_nvm_data(nvm_data),
      .o_conv_done(conv_done), .o_hum(hum), .o_temp(temp));
   // clock
   initial begin
      forever #20 i_clock = ~i_clock;
   end
   // cycle count and hang guard
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // one-cycle strobes, held across the taking edge
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge i_clock);
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      @(negedge i_clock);
      i_wr = 1'b0;
   endtask
   task automatic chk(input logic [6:0] a, input logic [7:0] e);
      @(negedge i_clock);
      i_addr = a;
      i_rd = 1'b1;
      @(negedge i_clock);
      i_rd = 1'b0;
      cmp({8'h00, o_rdata}, {8'h00, e}, "read");
   endtask
   task automatic wait_lvl(ref logic s, input logic v, input int lim);
      int n;
      n = 0;
      while (s !== v && n < lim) begin
         @(negedge i_clock);
         n++;
      end
      cmp({15'h0000, s}, {15'h0000, v}, "wait");
   endtask
   task automatic one_shot();
      wr(A_CTRL2, 8'h01);
      wait_lvl(o_conv_start, 1'b1, 20);
      wait_lvl(conv_done, 1'b1, 40);
      @(negedge i_clock);
   endtask
   // main sequence
   initial begin
      repeat (6) @(negedge i_clock);
      i_rst_n = 1'b1;
      k = 0;
      while (o_boot_busy === 1'b1 && k < 40) begin
         k++;
         @(negedge i_clock);
      end
      cmp(16'(k), 16'h0010, "copy length");
      for (int i = 0; i < 16; i++) chk(A_CALIB + 7'(i), 8'h3C ^ {i[3:0], i[3:0]});
      chk(A_AVG_CFG, R_AVG_CFG);
      cmp({7'h00, o_temp_avg_count}, 16'h0010, "temp count");
      chk(A_CTRL1, 8'h00);
      chk(A_CTRL2, 8'h00);
      chk(A_CTRL3, 8'h00);
      chk(A_STATUS, 8'h00);
      wr(A_DEVICE_ID, ~DEVICE_ID_CODE);
      chk(A_DEVICE_ID, DEVICE_ID_CODE);
      // holes are only read, the host never writes them
      chk(7'h00, 8'h00);
      chk(7'h26, 8'h00);
      for (int c = 0; c < 8; c++) begin
         wr(A_AVG_CFG, {2'h3, c[2:0], c[2:0]});
         chk(A_AVG_CFG, {2'h0, c[2:0], c[2:0]});
         cmp({7'h00, o_temp_avg_count}, 16'h0002 << c, "temp count");
         cmp({6'h00, o_hum_avg_count}, 16'h0004 << c, "hum count");
      end
      wr(A_CTRL3, 8'hFF);
      chk(A_CTRL3, M_CTRL3);
      wr(A_CTRL1, 8'h7B);
      chk(A_CTRL1, 8'h03);
      wr(A_CTRL2, 8'h7E);
      chk(A_CTRL2, 8'h02);
      wr(A_CTRL1, 8'h80);
      cmp({14'h0000, o_active, o_heater_en}, 16'h0003, "active heater");
      wr(A_CTRL2, 8'h00);
      cmp({15'h0000, o_heater_en}, 16'h0000, "heater");
      // slow one-shot: bit stands while converting
      wr(A_CTRL2, 8'h01);
      chk(A_CTRL2, 8'h01);
      wait_lvl(conv_done, 1'b1, 60);
      @(negedge i_clock);
      chk(A_CTRL2, 8'h00);
      chk(A_STATUS, 8'h03);
      chk(A_HUM_L, mdl.hum_v[7:0]);
      chk(A_HUM_H, mdl.hum_v[15:8]);
      chk(A_STATUS, 8'h01);
      chk(A_TEMP_L, mdl.temp_v[7:0]);
      chk(A_TEMP_H, mdl.temp_v[15:8]);
      chk(A_STATUS, 8'h00);
      // no hold: a half read does not freeze the pair
      chk(A_HUM_L, mdl.hum_v[7:0]);
      one_shot();
      chk(A_HUM_H, mdl.hum_v[15:8]);
      // hold: half read freezes until the other half
      wr(A_CTRL1, 8'h84);
      one_shot();
      h1 = mdl.hum_v;
      t1 = mdl.temp_v;
      chk(A_HUM_L, h1[7:0]);
      chk(A_TEMP_H, t1[15:8]);
      one_shot();
      chk(A_STATUS, 8'h03);
      chk(A_HUM_H, h1[15:8]);
      chk(A_TEMP_L, t1[7:0]);
      chk(A_HUM_L, mdl.hum_v[7:0]);
      // reload picks up changed trim memory
      trim_xor = 8'hA5;
      wr(A_CTRL2, 8'h80);
      chk(A_CTRL2, 8'h80);
      wait_lvl(o_boot_busy, 1'b0, 30);
      chk(A_CTRL2, 8'h00);
      for (int i = 0; i < 16; i++) chk(A_CALIB + 7'(i), 8'h99 ^ {i[3:0], i[3:0]});
      // periodic rates with a prompt engine
      slow = 1'b0;
      for (int r = 1; r < 4; r++) begin
         wr(A_CTRL1, 8'h80 | 8'(r));
         wait_lvl(o_conv_start, 1'b1, 100);
         t0 = cyc;
         @(negedge i_clock);
         wait_lvl(o_conv_start, 1'b1, 100);
         cmp(16'(cyc - t0), 16'(PER[r-1]), "rate period");
         wr(A_CTRL1, 8'h80);
         repeat (8) @(negedge i_clock);
      end
      chk(A_STATUS, 8'h03);
      wrap_up();
   end
endmodule
